// ---- src/fmr_defs.vh ----
// Constants for the file-move-or-return execution block
`ifndef FMR_DEFS_VH
`define FMR_DEFS_VH

// Register byte addresses on the Avalon-MM slave
`define FMR_ADDR_W          10
`define FMR_ADDR_INSTR      10'h000
`define FMR_ADDR_ACC        10'h004
`define FMR_ADDR_STATUS     10'h008
`define FMR_ADDR_PC         10'h00c
// File register window: address bit 9 set, word index in bits 8:2
`define FMR_FILE_WIN_BIT    9
`define FMR_FILE_IDX_HI     8
`define FMR_FILE_IDX_LO     2

// Status register fields
`define FMR_ST_ZERO         0
`define FMR_ST_GIE          1
`define FMR_ST_BUSY         2

// Widths
`define FMR_DATA_W          8
`define FMR_FADDR_W         7
`define FMR_PC_W            13
`define FMR_INSTR_W         14
`define FMR_FILE_DEPTH      128

// Reset values, step sizes and the zero byte
`define FMR_ACC_RST         8'h00
`define FMR_PC_RST          13'h0000
`define FMR_INSTR_RST       14'h0000
`define FMR_PC_STEP         13'h0001
`define FMR_INC_STEP        8'h01
`define FMR_ZERO_BYTE       8'h00

// Instruction fields
`define FMR_DEST_BIT        7
`define FMR_FADDR_HI        6
`define FMR_LIT_HI          7

// Opcode masks and match values
`define FMR_MASK_MOVE_TO_F  14'h3f80
`define FMR_CODE_STORE_ACC  14'h0080
`define FMR_MASK_FILE_OP    14'h3f00
`define FMR_CODE_INCREMENT  14'h0a00
`define FMR_CODE_OR_ACC     14'h0400
`define FMR_CODE_COPY_FILE  14'h0800
`define FMR_MASK_EXACT      14'h3fff
`define FMR_CODE_IRQ_RETURN 14'h0009
`define FMR_MASK_LIT_OP     14'h3c00
`define FMR_CODE_LOAD_LIT   14'h3000
`define FMR_CODE_RET_LIT    14'h3400

// One-hot operation positions
`define FMR_OPS             7
`define FMR_OP_STORE        0
`define FMR_OP_INC          1
`define FMR_OP_OR           2
`define FMR_OP_COPY         3
`define FMR_OP_IRET         4
`define FMR_OP_LDLIT        5
`define FMR_OP_RETLIT       6

`endif

// ---- src/fmr_file_ram.v ----
// File register array: one synchronous write port, one combinational read port
`include "fmr_defs.vh"
`default_nettype none

module fmr_file_ram
(
    input  wire                      sys_clk,
    input  wire                      wr_en,
    input  wire [`FMR_FADDR_W-1:0]   wr_addr,
    input  wire [`FMR_DATA_W-1:0]    wr_data,
    input  wire [`FMR_FADDR_W-1:0]   rd_addr,
    output wire [`FMR_DATA_W-1:0]    rd_data
);

    reg [`FMR_DATA_W-1:0] mem [0:`FMR_FILE_DEPTH-1];

    always @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule // fmr_file_ram

`default_nettype wire

// ---- src/fmr_exec.v ----
// Execution unit for file-move, literal and return instructions with an Avalon-MM slave
`include "fmr_defs.vh"
`default_nettype none

// What this block does
// [RULE_01] A file operation with destination bit 0 writes the accumulator, with bit 1 the addressed file register.
// [RULE_02] Increment-file adds one to the file value, routes it by the destination bit and changes only the zero flag.
// [RULE_03] OR-accumulator-with-file ORs accumulator and file value, routes it by the destination bit and changes only the zero flag.
// [RULE_04] Copy-file passes the file value unchanged to the destination and always sets the zero flag from it.
// [RULE_05] Interrupt-return loads the program counter from the return stack head and sets the global interrupt enable, flags untouched.
// [RULE_06] Load-literal places the 8-bit literal in the accumulator and touches no flag.
// [RULE_07] Return-with-literal loads the literal into the accumulator and the program counter from the stack head, flags untouched.
// [RULE_08] Return-with-literal takes two instruction cycles, so the next instruction waits for the second to finish.
// [RULE_09] Store-accumulator copies the accumulator into the file register named by the 7-bit address, flags untouched.
// [RULE_10] Interrupt-return and return-with-literal take two cycles and pop one stack level; all other instructions here take one cycle.
module fmr_exec
(
    input  wire                      sys_clk,
    input  wire                      nrst,
    input  wire [`FMR_ADDR_W-1:0]    avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [31:0]               avs_writedata,
    output reg  [31:0]               avs_readdata,
    output reg                       avs_waitrequest,
    input  wire [`FMR_PC_W-1:0]      return_stack_head,
    output reg                       stack_pop,
    output reg                       global_irq_enable,
    output reg  [`FMR_PC_W-1:0]      prog_counter
);

    localparam [1:0] S_IDLE   = 2'b01;
    localparam [1:0] S_SECOND = 2'b10;

    reg  [1:0]                  state;
    reg  [1:0]                  next_state;
    reg  [`FMR_DATA_W-1:0]      acc;
    reg  [`FMR_DATA_W-1:0]      next_acc;
    reg                         zero_flag;
    reg                         next_zero;
    reg                         next_gie;
    reg  [`FMR_PC_W-1:0]        next_pc;
    reg  [`FMR_INSTR_W-1:0]     last_instr;
    reg                         next_pop;
    reg                         file_we;
    reg  [`FMR_DATA_W-1:0]      file_wdata;
    reg  [`FMR_DATA_W-1:0]      result;
    reg  [31:0]                 next_rdata;

    wire                        accept;
    wire                        hit_instr;
    wire [`FMR_INSTR_W-1:0]     instr;
    wire [`FMR_OPS-1:0]         op;
    wire                        dest_file;
    wire [`FMR_FADDR_W-1:0]     file_addr;
    wire [`FMR_DATA_W-1:0]      file_val;
    wire [`FMR_DATA_W-1:0]      literal;

    // Window decode, shared by the read and write paths
    function is_file_win;
        input [`FMR_ADDR_W-1:0] addr;
        begin
            is_file_win = addr[`FMR_FILE_WIN_BIT];
        end
    endfunction

    // Instruction word to one-hot operation; unknown codes give all zero
    function [`FMR_OPS-1:0] decode_op;
        input [`FMR_INSTR_W-1:0] iw;
        begin
            decode_op = {`FMR_OPS{1'b0}};
            decode_op[`FMR_OP_STORE]  = (iw & `FMR_MASK_MOVE_TO_F) == `FMR_CODE_STORE_ACC;
            decode_op[`FMR_OP_INC]    = (iw & `FMR_MASK_FILE_OP) == `FMR_CODE_INCREMENT;
            decode_op[`FMR_OP_OR]     = (iw & `FMR_MASK_FILE_OP) == `FMR_CODE_OR_ACC;
            decode_op[`FMR_OP_COPY]   = (iw & `FMR_MASK_FILE_OP) == `FMR_CODE_COPY_FILE;
            decode_op[`FMR_OP_IRET]   = (iw & `FMR_MASK_EXACT) == `FMR_CODE_IRQ_RETURN;
            decode_op[`FMR_OP_LDLIT]  = (iw & `FMR_MASK_LIT_OP) == `FMR_CODE_LOAD_LIT;
            decode_op[`FMR_OP_RETLIT] = (iw & `FMR_MASK_LIT_OP) == `FMR_CODE_RET_LIT;
        end
    endfunction

    // One access at a time; nothing is taken during the second cycle of a return
    assign accept    = (avs_read | avs_write) & avs_waitrequest & state[0];
    assign hit_instr = avs_address == `FMR_ADDR_INSTR;
    assign instr     = avs_writedata[`FMR_INSTR_W-1:0];
    assign op        = decode_op(instr);
    assign dest_file = instr[`FMR_DEST_BIT];
    assign literal   = instr[`FMR_LIT_HI:0];
    assign file_addr = (avs_write & hit_instr) ? instr[`FMR_FADDR_HI:0]
                                               : avs_address[`FMR_FILE_IDX_HI:`FMR_FILE_IDX_LO];

    fmr_file_ram u_file_ram
    (
        .sys_clk (sys_clk),
        .wr_en   (file_we),
        .wr_addr (file_addr),
        .wr_data (file_wdata),
        .rd_addr (file_addr),
        .rd_data (file_val)
    );

    always @*
    begin
        next_state = state;
        next_acc   = acc;
        next_zero  = zero_flag;
        next_gie   = global_irq_enable;
        next_pc    = prog_counter;
        next_pop   = 1'b0;
        file_we    = 1'b0;
        file_wdata = acc;
        result     = file_val;
        case (state)
            S_IDLE:
            begin
                if (accept & avs_write & hit_instr)
                begin
                    next_pc = prog_counter + `FMR_PC_STEP;
                    if (op[`FMR_OP_INC])
                    begin
                        result    = file_val + `FMR_INC_STEP;                   // see [RULE_02]
                        next_zero = result == `FMR_ZERO_BYTE;                    // see [RULE_02]
                    end
                    else if (op[`FMR_OP_OR])
                    begin
                        result    = acc | file_val;                              // see [RULE_03]
                        next_zero = result == `FMR_ZERO_BYTE;                    // see [RULE_03]
                    end
                    else if (op[`FMR_OP_COPY])
                    begin
                        result    = file_val;                                    // see [RULE_04]
                        next_zero = file_val == `FMR_ZERO_BYTE;                  // see [RULE_04]
                    end
                    if (op[`FMR_OP_INC] | op[`FMR_OP_OR] | op[`FMR_OP_COPY])
                    begin
                        if (dest_file)
                        begin
                            file_we    = 1'b1;                                   // see [RULE_01]
                            file_wdata = result;
                        end
                        else
                        begin
                            next_acc = result;                                   // see [RULE_01]
                        end
                    end
                    if (op[`FMR_OP_STORE])
                    begin
                        file_we    = 1'b1;                                       // see [RULE_09]
                        file_wdata = acc;
                    end
                    if (op[`FMR_OP_LDLIT] | op[`FMR_OP_RETLIT])
                    begin
                        next_acc = literal;                                      // see [RULE_06] [RULE_07]
                    end
                    if (op[`FMR_OP_IRET])
                    begin
                        next_gie = 1'b1;                                         // see [RULE_05]
                    end
                    if (op[`FMR_OP_IRET] | op[`FMR_OP_RETLIT])
                    begin
                        next_pc    = return_stack_head;                          // see [RULE_05] [RULE_07]
                        next_pop   = 1'b1;                                       // see [RULE_10]
                        next_state = S_SECOND;                                   // see [RULE_08] [RULE_10]
                    end
                end
                else if (accept & avs_write)
                begin
                    if (is_file_win(avs_address))
                    begin
                        file_we    = 1'b1;
                        file_wdata = avs_writedata[`FMR_DATA_W-1:0];
                    end
                    else if (avs_address == `FMR_ADDR_ACC)
                    begin
                        next_acc = avs_writedata[`FMR_DATA_W-1:0];
                    end
                    else if (avs_address == `FMR_ADDR_STATUS)
                    begin
                        next_zero = avs_writedata[`FMR_ST_ZERO];
                        next_gie  = avs_writedata[`FMR_ST_GIE];
                    end
                    else if (avs_address == `FMR_ADDR_PC)
                    begin
                        next_pc = avs_writedata[`FMR_PC_W-1:0];
                    end
                end
            end
            S_SECOND:
            begin
                // Flushed slot of a return; the next instruction waits for it
                next_state = S_IDLE;                                             // see [RULE_08] [RULE_10]
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Read data mux; unmapped addresses read zero
    always @*
    begin
        next_rdata = 32'h00000000;
        if (is_file_win(avs_address))
        begin
            next_rdata[`FMR_DATA_W-1:0] = file_val;
        end
        else if (avs_address == `FMR_ADDR_INSTR)
        begin
            next_rdata[`FMR_INSTR_W-1:0] = last_instr;
        end
        else if (avs_address == `FMR_ADDR_ACC)
        begin
            next_rdata[`FMR_DATA_W-1:0] = acc;
        end
        else if (avs_address == `FMR_ADDR_STATUS)
        begin
            next_rdata[`FMR_ST_ZERO] = zero_flag;
            next_rdata[`FMR_ST_GIE]  = global_irq_enable;
            next_rdata[`FMR_ST_BUSY] = state[1];
        end
        else if (avs_address == `FMR_ADDR_PC)
        begin
            next_rdata[`FMR_PC_W-1:0] = prog_counter;
        end
    end

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state             <= S_IDLE;
            acc               <= `FMR_ACC_RST;
            zero_flag         <= 1'b0;
            global_irq_enable <= 1'b0;
            prog_counter      <= `FMR_PC_RST;
            last_instr        <= `FMR_INSTR_RST;
            stack_pop         <= 1'b0;
            avs_waitrequest   <= 1'b1;
            avs_readdata      <= 32'h00000000;
        end
        else
        begin
            state             <= next_state;
            acc               <= next_acc;
            zero_flag         <= next_zero;
            global_irq_enable <= next_gie;
            prog_counter      <= next_pc;
            stack_pop         <= next_pop;
            avs_waitrequest   <= ~accept;
            if (accept & avs_read)
            begin
                avs_readdata <= next_rdata;
            end
            if (accept & avs_write & hit_instr)
            begin
                last_instr <= instr;
            end
        end
    end

endmodule // fmr_exec

`default_nettype wire

// ---- dv/fmr_exec_assertions.sv ----
// Concurrent checks on the ports of the execution unit
`default_nettype none
module fmr_exec_chk
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [12:0] return_stack_head,
    input wire logic        stack_pop,
    input wire logic        global_irq_enable,
    input wire logic [12:0] prog_counter
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic inst_ack;
    logic ret_code;
    assign inst_ack = !avs_waitrequest && avs_write && avs_address == 10'h000;
    assign ret_code = avs_writedata[13:0] == 14'h0009 || avs_writedata[13:10] == 4'hd;

    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack held");
    a_pop_on_ret: assert property (stack_pop |-> inst_ack && ret_code) else $error("stray pop");
    a_ret_pops: assert property (inst_ack && ret_code |-> stack_pop) else $error("no pop");
    a_ret_loads_pc: assert property (stack_pop |-> prog_counter == $past(return_stack_head))
        else $error("pc not from stack head");
    a_dead_slot: assert property (stack_pop |=> $stable(prog_counter) && avs_waitrequest)
        else $error("second cycle not idle");
    a_iret_sets_gie: assert property (stack_pop && avs_writedata[13:0] == 14'h0009
        |-> global_irq_enable) else $error("gie not set");
    a_step_pc: assert property (inst_ack && !stack_pop
        |-> prog_counter == $past(prog_counter) + 13'h0001) else $error("pc not stepped");
    a_gie_cause: assert property ($rose(global_irq_enable)
        |-> avs_write && (avs_address == 10'h008 || stack_pop)) else $error("gie rose without cause");
    a_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address == 10'h010 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    // Checked from the second edge of a reset on, once the asynchronous clear has surely landed
    a_reset_state: assert property (disable iff (1'b0) !nrst ##1 !nrst |-> avs_waitrequest && !stack_pop
        && !global_irq_enable && prog_counter == 13'h0000) else $error("reset state");
    c_iret: cover property (stack_pop && global_irq_enable);
    c_plain: cover property (inst_ack && !stack_pop);
    c_after_ret: cover property (stack_pop ##2 !avs_waitrequest);
endmodule // fmr_exec_chk
bind fmr_exec fmr_exec_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .return_stack_head(return_stack_head), .stack_pop(stack_pop),
    .global_irq_enable(global_irq_enable), .prog_counter(prog_counter));
`default_nettype wire

// ---- dv/fmr_exec_tb_top.sv ----
// Self-checking bench for the execution unit
`default_nettype none
module fmr_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [12:0] return_stack_head = 13'h0000;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire         stack_pop;
    wire         global_irq_enable;
    wire  [12:0] prog_counter;
    int          mismatches = 0;
    int          checks_done = 0;
    int          pops = 0;
    int          n;
    logic [31:0] v;
    fmr_exec uut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .return_stack_head(return_stack_head), .stack_pop(stack_pop),
        .global_irq_enable(global_irq_enable), .prog_counter(prog_counter));
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (stack_pop === 1'b1) pops <= pops + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] e);
        checks_done++;
        if (seen !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, e);
        end
    endtask
    // Holds the request until waitrequest is sampled low, then lets one edge pass
    task automatic bus(input logic [9:0] a, input logic wr, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic ex(input logic [13:0] iw); bus(10'h000, 1'b1, {18'h0, iw}); endtask
    task automatic fw(input logic [6:0] f, input logic [7:0] d); bus({1'b1, f, 2'b00}, 1'b1, {24'h0, d}); endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] e); bus(a, 1'b0, 32'h0); chk(v, e); endtask
    task automatic fc(input logic [6:0] f, input logic [7:0] e); rc({1'b1, f, 2'b00}, {24'h0, e}); endtask
    task automatic t_reset;
        rc(10'h000, 32'h0); rc(10'h004, 32'h0); rc(10'h008, 32'h0); rc(10'h00c, 32'h0); rc(10'h010, 32'h0);
    endtask
    task automatic t_literal_store;
        ex(14'h335a); rc(10'h004, 32'h5a); rc(10'h008, 32'h0);
        fw(7'd8, 8'h00); ex(14'h0888); rc(10'h008, 32'h1);
        ex(14'h30a5); rc(10'h004, 32'ha5); rc(10'h008, 32'h1);
        ex(14'h00ff); fc(7'd127, 8'ha5); rc(10'h008, 32'h1);
        rc(10'h000, 32'h00ff);
    endtask
    task automatic t_increment;
        fw(7'd5, 8'hff); ex(14'h0a05); rc(10'h004, 32'h0); rc(10'h008, 32'h1);
        fc(7'd5, 8'hff);
        fw(7'd6, 8'h10); ex(14'h0a86); fc(7'd6, 8'h11); rc(10'h004, 32'h0);
        rc(10'h008, 32'h0);
    endtask
    task automatic t_or;
        ex(14'h300f); fw(7'd7, 8'hf0); ex(14'h0487); fc(7'd7, 8'hff); rc(10'h004, 32'h0f);
        rc(10'h008, 32'h0);
        ex(14'h3000); fw(7'd9, 8'h00); ex(14'h0409); rc(10'h004, 32'h0); rc(10'h008, 32'h1);
    endtask
    task automatic t_copy;
        fw(7'd10, 8'h3c); ex(14'h080a); rc(10'h004, 32'h3c); rc(10'h008, 32'h0); fc(7'd10, 8'h3c);
    endtask
    task automatic t_pc_step;
        bus(10'h00c, 1'b1, 32'h0100); ex(14'h3000); rc(10'h00c, 32'h0101);
        ex(14'h0000); rc(10'h00c, 32'h0102);
    endtask
    task automatic t_ret_literal;
        return_stack_head <= 13'h1abc;
        n = pops;
        ex(14'h34ff); rc(10'h004, 32'hff); rc(10'h00c, 32'h1abc); rc(10'h008, 32'h0);
        chk(pops - n, 32'h1);
        // Back to back: a read raised right after the return's answer is taken once the dead slot is over
        avs_address   <= 10'h000;
        avs_writedata <= 32'h0000345a;
        avs_write     <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        avs_write   <= 1'b0;
        avs_read    <= 1'b1;
        avs_address <= 10'h004;
        n = 0;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            @(posedge sys_clk);
        end
        avs_read <= 1'b0;
        chk(avs_readdata, 32'h5a);
        chk(n, 32'h1);
        @(posedge sys_clk);
    endtask
    task automatic t_int_return;
        bus(10'h008, 1'b1, 32'h1);
        return_stack_head <= 13'h0123;
        n = pops;
        ex(14'h0009); rc(10'h008, 32'h3); rc(10'h00c, 32'h0123);
        chk({31'h0, global_irq_enable}, 32'h1);
        chk(pops - n, 32'h1);
        bus(10'h008, 1'b1, 32'h4); rc(10'h008, 32'h0);
    endtask
    task automatic t_second_reset;
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rc(10'h00c, 32'h0); rc(10'h004, 32'h0); rc(10'h008, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #50000;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset(); t_literal_store(); t_increment(); t_or(); t_copy(); t_pc_step();
        t_ret_literal(); t_int_return(); t_second_reset();
        tally_and_finish();
    end
endmodule // fmr_exec_tb_top
`default_nettype wire
